// ==== hw/dlid_decoder.sv ====
// instruction decoder for a drive's serial link
`timescale 1ns/1ps
`default_nettype none
`include "dlid_defs.svh"

module dlid_decoder (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // instruction request
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [7:0] code_i,
    input wire logic [15:0] wdata_i,
    // drive state, from logic on this clock
    input wire logic [7:0] fault_code_i [`DLID_FAULT_DEPTH],
    input wire logic [7:0] out_state_i,
    input wire logic speed_display_parameter_i,
    input wire logic [7:0] link_ext_i,
    // reply
    output logic ack_o,
    output logic err_o,
    output logic [15:0] rdata_o,
    output dlid_pkg::dlid_fmt_t fmt_o,
    // applied commands
    output logic forward_run_input_o,
    output logic reverse_run_input_o,
    output logic [7:0] run_cmd_o,
    output logic [7:0] mon_sel_o,
    output logic [15:0] freq_set_o,
    output logic nv_wr_o,
    output logic [15:0] nv_data_o
);
    import dlid_pkg::*;

    // ------------------------------------------------------------
    // code decode
    // ------------------------------------------------------------
    logic is_fault;
    logic is_run;
    logic is_stat;
    logic is_frd_v;
    logic is_frd_nv;
    logic is_fwr_v;
    logic is_fwr_nv;
    logic is_mon;
    logic rd_known;
    logic wr_known;
    logic known;
    logic take_rd;
    logic take_wr;
    logic speed_ext;
    logic [1:0] fidx;
    logic [15:0] fault_pair [`DLID_FAULT_PAIRS];
    logic [15:0] rdata_d;
    dlid_fmt_t fmt_d;
    logic [7:0] run_q;
    logic [7:0] mon_q;
    logic [15:0] freq_q;
    logic [15:0] nv_q;

    assign is_fault = (code_i >= `DLID_CODE_FAULT_LO) && (code_i <= `DLID_CODE_FAULT_HI);
    assign is_run = (code_i == `DLID_CODE_RUN_EXT) || (code_i == `DLID_CODE_RUN);
    assign is_stat = (code_i == `DLID_CODE_STAT_EXT) || (code_i == `DLID_CODE_STAT);
    assign is_frd_v = code_i == `DLID_CODE_FREQ_RD_V;
    assign is_frd_nv = code_i == `DLID_CODE_FREQ_RD_NV;
    assign is_fwr_v = code_i == `DLID_CODE_FREQ_WR_V;
    assign is_fwr_nv = code_i == `DLID_CODE_FREQ_WR_NV;
    assign is_mon = code_i == `DLID_CODE_MON_SEL;

    // a code is honoured only in its own direction; the other one is refused with no state change
    assign rd_known = is_fault || is_stat || is_frd_v || is_frd_nv;
    assign wr_known = is_run || is_fwr_v || is_fwr_nv || is_mon;
    assign known = wr_i ? wr_known : rd_known;
    assign take_rd = req_i && !wr_i && rd_known;
    assign take_wr = req_i && wr_i && wr_known;

    // ------------------------------------------------------------
    // fault history pairs
    // ------------------------------------------------------------
    // record 0 is the latest; each pair carries its older record in the high byte
    for (genvar p = 0; p < `DLID_FAULT_PAIRS; p = p + 1) begin : g_fault_pair
        assign fault_pair[p] = {fault_code_i[2 * p + 1], fault_code_i[2 * p]};
    end
    assign fidx = code_i[1:0];

    // ------------------------------------------------------------
    // read data and reply format
    // ------------------------------------------------------------
    // speed scaling only changes units and reply length; the stored word is taken as is
    assign speed_ext = speed_display_parameter_i && (link_ext_i == `DLID_EXT_ON);

    always_comb begin
        rdata_d = 16'h0000;
        if (is_fault) begin
            rdata_d = fault_pair[fidx];
        end else if (is_stat) begin
            rdata_d = {8'h00, out_state_i};
        end else if (is_frd_v) begin
            rdata_d = freq_q;
        end else if (is_frd_nv) begin
            rdata_d = nv_q;
        end
    end

    always_comb begin
        fmt_d = DLID_FMT_STD;
        if ((is_frd_v || is_frd_nv) && speed_ext) begin
            fmt_d = DLID_FMT_EXT;
        end
    end

    // ------------------------------------------------------------
    // reply
    // ------------------------------------------------------------
    // ack and err are one-cycle pulses, one edge after the request is taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req_i && known;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_o <= 1'b0;
        end else begin
            err_o <= req_i && !known;
        end
    end

    // read data and format hold until the next accepted read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (take_rd) begin
            rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fmt_o <= DLID_FMT_NONE;
        end else if (take_rd) begin
            fmt_o <= fmt_d;
        end
    end

    // ------------------------------------------------------------
    // run command and monitor selection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 8'h00;
        end else if (take_wr && is_run) begin
            run_q <= wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mon_q <= `DLID_MON_RST;
        end else if (take_wr && is_mon) begin
            mon_q <= wdata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // set frequency storage
    // ------------------------------------------------------------
    // the host keeps writes at or below the 400 Hz code; out-of-range words are still stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            freq_q <= `DLID_FREQ_RST;
        end else if (take_wr && (is_fwr_v || is_fwr_nv)) begin
            freq_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_q <= `DLID_FREQ_RST;
        end else if (take_wr && is_fwr_nv) begin
            nv_q <= wdata_i;
        end
    end

    // one pulse per dual write, so the slow store is committed exactly once
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_wr_o <= 1'b0;
        end else begin
            nv_wr_o <= take_wr && is_fwr_nv;
        end
    end

    // ------------------------------------------------------------
    // applied outputs
    // ------------------------------------------------------------
    assign forward_run_input_o = run_q[`DLID_RUN_FWD_BIT];
    assign reverse_run_input_o = run_q[`DLID_RUN_REV_BIT];
    assign run_cmd_o = run_q;
    assign mon_sel_o = mon_q;
    assign freq_set_o = freq_q;
    assign nv_data_o = nv_q;

endmodule // dlid_decoder
`default_nettype wire

// ==== hw/dlid_defs.svh ====
// constants for the drive link instruction decoder
`ifndef DLID_DEFS_SVH
`define DLID_DEFS_SVH

// instruction codes
`define DLID_CODE_FAULT_LO   8'h74
`define DLID_CODE_FAULT_HI   8'h77
`define DLID_CODE_RUN_EXT    8'hF9
`define DLID_CODE_RUN        8'hFA
`define DLID_CODE_STAT_EXT   8'h79
`define DLID_CODE_STAT       8'h7A
`define DLID_CODE_FREQ_RD_V  8'h6D
`define DLID_CODE_FREQ_RD_NV 8'h6E
`define DLID_CODE_FREQ_WR_V  8'hED
`define DLID_CODE_FREQ_WR_NV 8'hEE
`define DLID_CODE_MON_SEL    8'hF3

// limits and reset values
`define DLID_FREQ_MAX        16'h9C40
`define DLID_FREQ_RST        16'h0000
`define DLID_MON_RST         8'h01
`define DLID_EXT_ON          8'h01
`define DLID_FAULT_DEPTH     8
`define DLID_FAULT_PAIRS 4

// run command bit positions
`define DLID_RUN_FWD_BIT 1
`define DLID_RUN_REV_BIT 2

`endif

// ==== hw/dlid_pkg.sv ====
// types for the drive link instruction decoder
`default_nettype none
package dlid_pkg;
    typedef enum logic [1:0] {
        DLID_FMT_STD,
        DLID_FMT_EXT,
        DLID_FMT_NONE
    } dlid_fmt_t;
endpackage
`default_nettype wire

// ==== tb/dlid_decoder_monitor.sv ====
// assertions on the instruction decoder ports
`timescale 1ns/1ps
`default_nettype none
module dlid_decoder_monitor (
    input wire logic clk_i, rst_i, req_i, wr_i, speed_display_parameter_i,
    input wire logic [7:0] code_i, out_state_i, link_ext_i, run_cmd_o, mon_sel_o,
    input wire logic [15:0] wdata_i, rdata_o, freq_set_o, nv_data_o,
    input wire logic ack_o, err_o, nv_wr_o, forward_run_input_o, reverse_run_input_o,
    input wire dlid_pkg::dlid_fmt_t fmt_o
);
    import dlid_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd = req_i && !wr_i;
    wire logic wt = req_i && wr_i;
    a_read_ram: assert property (rd && code_i == 8'h6D |=> ack_o && rdata_o == $past(freq_set_o))
        else $error("volatile read wrong");
    a_write_both: assert property (wt && code_i == 8'hEE |=> nv_wr_o && nv_data_o == $past(wdata_i))
        else $error("dual store wrong");
    a_write_ram: assert property (wt && code_i == 8'hED |=> !nv_wr_o && $stable(nv_data_o))
        else $error("volatile store touched copy");
    a_run_word: assert property (wt && code_i == 8'hFA |=> {8'h00, run_cmd_o} == ($past(wdata_i) & 16'h00FF))
        else $error("run word wrong");
    a_run_pins: assert property (wt && (code_i == 8'hFA || code_i == 8'hF9)
        |=> {13'h0, reverse_run_input_o, forward_run_input_o, 1'b0} == ($past(wdata_i) & 16'h0006))
        else $error("run pins wrong");
    a_status_read: assert property (rd && code_i == 8'h7A |=> ack_o && rdata_o[7:0] == $past(out_state_i))
        else $error("status read wrong");
    a_fmt_ext: assert property (rd && code_i == 8'h6D && speed_display_parameter_i && link_ext_i == 8'h01
        |=> fmt_o == DLID_FMT_EXT)
        else $error("reply format wrong");
    a_fmt_std: assert property (rd && code_i == 8'h6D && !speed_display_parameter_i
        |=> fmt_o == DLID_FMT_STD)
        else $error("standard format wrong");
    a_read_nv: assert property (rd && code_i == 8'h6E |=> ack_o && rdata_o == $past(nv_data_o))
        else $error("non-volatile read wrong");
    a_refuse_dir: assert property (rd && code_i == 8'hF3 |=> err_o && !ack_o)
        else $error("wrong direction not refused");
    a_mon_sel: assert property (wt && code_i == 8'hF3 |=> {8'h00, mon_sel_o} == ($past(wdata_i) & 16'h00FF))
        else $error("monitor selection wrong");
endmodule // dlid_decoder_monitor
bind dlid_decoder dlid_decoder_monitor i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i),
    .speed_display_parameter_i(speed_display_parameter_i),
    .code_i(code_i), .out_state_i(out_state_i), .link_ext_i(link_ext_i), .run_cmd_o(run_cmd_o),
    .mon_sel_o(mon_sel_o), .wdata_i(wdata_i), .rdata_o(rdata_o), .freq_set_o(freq_set_o),
    .nv_data_o(nv_data_o), .ack_o(ack_o), .err_o(err_o), .nv_wr_o(nv_wr_o),
    .forward_run_input_o(forward_run_input_o), .reverse_run_input_o(reverse_run_input_o), .fmt_o(fmt_o)
);
`default_nettype wire

// ==== tb/dlid_host.sv ====
// host model issuing link instructions
`timescale 1ns/1ps
`default_nettype none
module dlid_host (
    input wire logic clk_i,
    output logic req_o, wr_o,
    output logic [7:0] code_o,
    output logic [15:0] wdata_o
);
    initial {req_o, wr_o, code_o, wdata_o} = '0;
    // frequency writes kept to the 400 Hz code: the decoder never clips them
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        req_o = 1'h1;
        wr_o = w;
        code_o = c;
        wdata_o = (w && (c == 8'hED || c == 8'hEE) && d > 16'h9C40) ? 16'h9C40 : d;
        @(posedge clk_i);
        #1;
        req_o = 1'h0;
        wdata_o = ~wdata_o;
    endtask
endmodule // dlid_host
`default_nettype wire

// ==== tb/dlid_decoder_tb_top.sv ====
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module dlid_decoder_tb_top;
    import dlid_pkg::*;
    logic clk_i = 0, rst_i = 1, sd = 0;
    logic [7:0] st = 8'h05, ext = 8'h00;
    logic [7:0] flt [8];
    wire logic req, wr, ack, err, fwd, rev, nvw;
    wire logic [7:0] code, run, mon;
    wire logic [15:0] wd, rd, frq, nvd;
    wire dlid_fmt_t fmt;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    dlid_host i_host (.clk_i, .req_o(req), .wr_o(wr), .code_o(code), .wdata_o(wd));
    dlid_decoder i_dut (.clk_i, .rst_i, .req_i(req), .wr_i(wr), .code_i(code), .wdata_i(wd), .fault_code_i(flt),
        .out_state_i(st), .speed_display_parameter_i(sd), .link_ext_i(ext), .ack_o(ack), .err_o(err),
        .rdata_o(rd), .fmt_o(fmt), .forward_run_input_o(fwd), .reverse_run_input_o(rev), .run_cmd_o(run),
        .mon_sel_o(mon), .freq_set_o(frq), .nv_wr_o(nvw), .nv_data_o(nvd));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // about 40 cycles of traffic; the ceiling leaves ample slack
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 500) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic t_freq;
        i_host.send(1, 8'hEE, 16'hFFFF);
        chk("ack", {15'h0, ack}, 16'h1);
        chk("nv", nvd, 16'h9C40);
        chk("nv_wr_on", {15'h0, nvw}, 16'h1);
        chk("frq_both", frq, 16'h9C40);
        i_host.send(1, 8'hED, 16'h0001);
        chk("nv_wr", {15'h0, nvw}, 16'h0);
        chk("nv_keep", nvd, 16'h9C40);
        chk("frq_v", frq, 16'h0001);
        i_host.send(0, 8'h6E, 16'h0);
        chk("rd_nv", rd, 16'h9C40);
        i_host.send(0, 8'h6D, 16'h0);
        chk("rd_v", rd, 16'h0001);
        $display("freq done");
    endtask
    task automatic t_fault;
        for (int k = 0; k < 4; k++) begin
            i_host.send(0, 8'h74 + 8'(k), 16'h0);
            chk("fault", rd, {flt[2*k+1], flt[2*k]});
        end
        $display("fault done");
    endtask
    task automatic t_cmd;
        i_host.send(1, 8'hFA, 16'hAA06);
        chk("run", {14'h0, rev, fwd}, 16'h3);
        chk("run_word", {8'h0, run}, 16'h0006);
        i_host.send(1, 8'hF9, 16'h0002);
        chk("run_x", {14'h0, rev, fwd}, 16'h1);
        i_host.send(1, 8'hF3, 16'h1233);
        chk("mon", {8'h0, mon}, 16'h0033);
        i_host.send(0, 8'hF3, 16'h0);
        chk("err", {15'h0, err}, 16'h1);
        chk("no_ack", {15'h0, ack}, 16'h0);
        @(posedge clk_i);
        #1;
        chk("err_pulse", {15'h0, err}, 16'h0);
        $display("cmd done");
    endtask
    task automatic t_reset;
        @(posedge clk_i);
        #1 rst_i = 1;
        repeat (2) @(posedge clk_i);
        #1 rst_i = 0;
        chk("rst_mon", {8'h0, mon}, 16'h0001);
        chk("rst_fmt", {14'h0, fmt}, {14'h0, DLID_FMT_NONE});
        chk("rst_frq", frq, 16'h0000);
        chk("rst_run", {8'h0, run}, 16'h0000);
        chk("rst_rd", rd, 16'h0000);
        i_host.send(0, 8'h6E, 16'h0);
        chk("rd_nv_rst", rd, 16'h0000);
        $display("reset done");
    endtask
    task automatic t_stat;
        i_host.send(0, 8'h7A, 16'h0);
        chk("stat", {8'h0, rd[7:0]}, {8'h0, st});
        sd = 1;
        ext = 8'h01;
        i_host.send(0, 8'h6D, 16'h0);
        chk("fmt", {14'h0, fmt}, {14'h0, DLID_FMT_EXT});
        ext = 8'h00;
        i_host.send(0, 8'h6D, 16'h0);
        chk("fmt_std", {14'h0, fmt}, {14'h0, DLID_FMT_STD});
        $display("stat done");
    endtask
    initial begin
        foreach (flt[i]) flt[i] = 8'hA0 + 8'(i);
        repeat (3) @(posedge clk_i);
        #1 rst_i = 0;
        t_freq();
        t_fault();
        t_cmd();
        t_stat();
        t_reset();
        stop_test();
    end
endmodule // dlid_decoder_tb_top
`default_nettype wire
